// [sim/bsc_host.sv]
// smbus host model for the backlight register block
`timescale 1ns/1ns
`include "bsc_consts.svh"
module bsc_host (
  // clock
  input wire logic clk,
  // open-drain lines, 1 means released
  output logic scl,
  output logic sda_o,
  input wire logic sda
);
  int q = 50;
  initial {scl, sda_o} = 2'b11;
  task automatic ph(input logic c, input logic d);
    scl = c;
    sda_o = d;
    repeat (q) @(negedge clk);
  endtask
  // v=1 start, v=0 stop; clock and data never move together
  task automatic cond(input logic v);
    ph(1'b0, sda_o);
    ph(1'b0, v);
    ph(1'b1, v);
    ph(1'b1, ~v);
  endtask
  task automatic bt(input logic b, output logic r);
    ph(1'b0, sda_o);
    ph(1'b0, b);
    ph(1'b1, b);
    r = sda;
  endtask
  task automatic xb(input logic [7:0] d, output logic [7:0] r, output logic n);
    for (int i = 7; i >= 0; i--)
      bt(d[i], r[i]);
    bt(1'b1, n);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] x, input logic [7:0] d,
    output logic [2:0] n);
    logic [7:0] r;
    cond(1'b1);
    xb({a, 1'b0}, r, n[2]);
    xb(x, r, n[1]);
    xb(d, r, n[0]);
    cond(1'b0);
  endtask
  // c=0 leaves out the command byte, which the device must refuse
  task automatic rd(input logic c, input logic [7:0] x, output logic [7:0] d,
    output logic [2:0] n);
    logic z;
    n = 3'h0;
    cond(1'b1);
    if (c) begin
      xb({`BSC_SLAVE_ADDR, 1'b0}, d, n[2]);
      xb(x, d, n[1]);
      cond(1'b1);
    end
    xb({`BSC_SLAVE_ADDR, 1'b1}, d, n[0]);
    xb(8'hFF, d, z);
    cond(1'b0);
  endtask
endmodule // bsc_host

// [sim/bsc_regs_props.sv]
// assertions on the ports of the backlight smbus register block
`timescale 1ns/1ns
`include "bsc_consts.svh"
module bsc_regs_props (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // smbus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input bsc_pkg::bsc_pin_drive_t pins,
  // pwm input
  input wire logic pwm_in,
  // backlight output
  input bsc_pkg::bsc_backlight_t backlight
);
  import bsc_pkg::*;
  localparam int ON_MAX = 200000;
  logic scl_q;
  logic sda_q;
  logic [5:0] bc;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [17:0] gap;
  wire logic rise = scl_in & ~scl_q;
  wire logic own_w = b1 == {`BSC_SLAVE_ADDR, 1'b0};
  // bit count restarts on every start, so a repeated start refills b1
  always_ff @(posedge clk) begin
    scl_q <= scl_in;
    sda_q <= sda_in;
    if (srst || (scl_in && scl_q && sda_q && !sda_in))
      bc <= 6'h00;
    else if (rise && bc != 6'h3F)
      bc <= bc + 6'h01;
    if (rise && bc < 6'h08)
      b1 <= {b1[6:0], sda_in};
    if (rise && bc > 6'h08 && bc < 6'h11)
      b2 <= {b2[6:0], sda_in};
    // gap restarts on every clock rise or driven low, so it times from the last bus event
    if (srst || !pins.sda_oe_n || rise)
      gap <= 18'h00000;
    else if (gap != 18'h3FFFF)
      gap <= gap + 18'h00001;
  end
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  scl_free_a: assert property (pins.scl_oe_n)
    else $error("clock line pulled");
  reset_out_a: assert property ($fell(srst) |->
    backlight.level == 8'hFF && !backlight.enable && pins.sda_oe_n) else $error("reset state");
  sda_move_a: assert property ($changed(pins.sda_oe_n) |-> !scl_in)
    else $error("data moved with clock high");
  own_ack_a: assert property (rise && bc == 6'h08 && own_w |-> !sda_in)
    else $error("own address not acked");
  other_nak_a: assert property (rise && bc == 6'h08 && b1[7:1] != `BSC_SLAVE_ADDR |-> sda_in)
    else $error("foreign address acked");
  index_nak_a: assert property (rise && bc == 6'h11 && own_w && b2 > 8'h02 |-> sda_in)
    else $error("bad index acked");
  on_time_a: assert property ($rose(backlight.enable) |-> gap < ON_MAX)
    else $error("switch on too late");
  off_now_a: assert property ($fell(backlight.enable) |-> gap < 18'd16)
    else $error("switch off late");
  wr_ack_c: cover property (rise && bc == 6'h11 && own_w && !sda_in);
  on_c: cover property ($rose(backlight.enable));
  nak_c: cover property (rise && bc == 6'h08 && sda_in);
endmodule // bsc_regs_props
bind bsc_regs bsc_regs_props chk_i (.clk(clk), .srst(srst), .scl_in(scl_in),
  .sda_in(sda_in), .pins(pins), .pwm_in(pwm_in), .backlight(backlight));

// [sim/tb.sv]
// self-checking bench for the backlight smbus register block
`timescale 1ns/1ns
`include "bsc_consts.svh"
module tb;
  import bsc_pkg::*;
  localparam logic [6:0] ADR = `BSC_SLAVE_ADDR;
  logic clk;
  logic srst;
  logic pwm_in;
  logic scl;
  logic sda_o;
  bsc_pin_drive_t pins;
  bsc_backlight_t bl;
  wire logic scl_w = scl & pins.scl_oe_n;
  wire logic sda_w = sda_o & pins.sda_oe_n;
  int err_total = 0;
  int check_count = 0;
  logic [7:0] rv;
  logic [2:0] nk;
  bsc_regs dut (.clk(clk), .srst(srst), .scl_in(scl_w), .sda_in(sda_w), .pins(pins),
    .pwm_in(pwm_in), .backlight(bl));
  bsc_host host (.clk(clk), .scl(scl), .sda_o(sda_o), .sda(sda_w));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdx(input logic [7:0] x, input logic [7:0] e);
    host.rd(1'b1, x, rv, nk);
    chk("read ack", 8'h00, {5'h0, nk});
    chk("read data", e, rv);
  endtask
  task automatic wrx(input logic [7:0] x, input logic [7:0] d);
    host.wr(ADR, x, d, nk);
    chk("write ack", 8'h00, {5'h0, nk});
  endtask
  task automatic t_reset();
    chk("level", 8'hFF, bl.level);
    chk("enable", 8'h00, {7'h0, bl.enable});
    rdx(8'h00, 8'hFF);
    rdx(8'h01, 8'h00);
  endtask
  // slow clock for the control write; the 1024 cycle on delay starts inside it, so it ends well before the 1100 cycle wait below is over
  task automatic t_ctrl();
    host.q = 121;
    wrx(8'h01, 8'hFF);
    host.q = 50;
    repeat (1100) @(negedge clk);
    chk("enable", 8'h01, {7'h0, bl.enable});
    chk("level", 8'hFF, bl.level);
    rdx(8'h01, 8'h07);
    rdx(8'h02, 8'h08);
    wrx(8'h00, 8'h40);
    chk("level", 8'hFF, bl.level);
    rdx(8'h00, 8'hFF);
  endtask
  task automatic t_smbus();
    wrx(8'h01, 8'h05);
    chk("level", 8'hFF, bl.level);
    wrx(8'h00, 8'h40);
    chk("level", 8'h40, bl.level);
    rdx(8'h00, 8'h40);
    wrx(8'h01, 8'h00);
    chk("enable", 8'h00, {7'h0, bl.enable});
    chk("level", 8'h40, bl.level);
  endtask
  task automatic t_refuse();
    host.wr(7'h59, 8'h00, 8'h11, nk);
    chk("nak addr", 8'h07, {5'h0, nk});
    host.wr(ADR, 8'h05, 8'h22, nk);
    chk("nak index", 8'h01, {6'h0, nk[2:1]});
    host.rd(1'b0, 8'h00, rv, nk);
    chk("nak nocmd", 8'h01, {7'h0, nk[0]});
    rdx(8'h00, 8'h40);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (95000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    srst = 1'b1;
    pwm_in = 1'b1; // full duty keeps scaled brightness equal to the register
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_ctrl();
    t_smbus();
    t_refuse();
    summarize();
  end
endmodule // tb

// [src/bsc_consts.svh]
// constants for the backlight smbus control register block
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH
`define BSC_SLAVE_ADDR 7'h58
`define BSC_IDX_BRIGHT 8'h00
`define BSC_IDX_CTRL 8'h01
`define BSC_IDX_STATUS 8'h02
`define BSC_BRIGHT_RST 8'hFF
`define BSC_CTRL_RST 3'h0
`define BSC_BIT_ON 0
`define BSC_BIT_SRC 1
`define BSC_BIT_INTERP 2
`define BSC_STAT_ON_BIT 3
`define BSC_CLK_HZ 20000000
`define BSC_ON_DELAY_MS 10
`define BSC_ON_DELAY_CYC ((`BSC_CLK_HZ / 1000) * `BSC_ON_DELAY_MS)
`define BSC_PWM_PERIOD 16'hFFFF
`define BSC_ON_CNT_LAST 19'h003FF
`endif

// [src/bsc_pkg.sv]
// types for the backlight smbus control register block
package bsc_pkg;
  typedef enum logic [6:0] {
    BSC_IDLE = 7'h01,
    BSC_ADDR = 7'h02,
    BSC_CMD = 7'h04,
    BSC_DATA = 7'h08,
    BSC_RDATA = 7'h10,
    BSC_ACK = 7'h20,
    BSC_SKIP = 7'h40
  } bsc_state_t;
  typedef struct packed {
    logic scl_oe_n;
    logic sda_oe_n;
  } bsc_pin_drive_t;
  typedef struct packed {
    logic [7:0] level;
    logic enable;
  } bsc_backlight_t;
endpackage

// [src/bsc_regs.sv]
// smbus slave with brightness and control registers for a backlight driver
`timescale 1ns/1ns
`include "bsc_consts.svh"
module bsc_regs (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // smbus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output bsc_pkg::bsc_pin_drive_t pins,
  // pwm input
  input wire logic pwm_in,
  // backlight output
  output bsc_pkg::bsc_backlight_t backlight
);
  import bsc_pkg::*;

  // ************************************************************
  // input synchronisers
  // ************************************************************
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] pwm_sync;
  logic scl_prev;
  logic sda_prev;
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      pwm_sync <= 2'h0;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      pwm_sync <= {pwm_sync[0], pwm_in};
      scl_prev <= scl_sync[1];
      sda_prev <= sda_sync[1];
    end
  end
  wire scl = scl_sync[1];
  wire sda = sda_sync[1];
  wire pwm = pwm_sync[1];
  wire scl_rise = scl & ~scl_prev;
  wire scl_fall = ~scl & scl_prev;
  wire start_cond = scl & scl_prev & sda_prev & ~sda;
  wire stop_cond = scl & scl_prev & ~sda_prev & sda;

  // ************************************************************
  // pwm duty measurement
  // ************************************************************
  // duty is sampled over a fixed window; the window is the scale factor
  logic [15:0] win_cnt;
  logic [15:0] high_cnt;
  logic [7:0] duty;
  wire win_end = (win_cnt == `BSC_PWM_PERIOD);
  always_ff @(posedge clk) begin
    if (srst) begin
      win_cnt <= 16'h0000;
      high_cnt <= 16'h0000;
      duty <= 8'hFF;
    end else begin
      win_cnt <= win_end ? 16'h0000 : win_cnt + 16'h0001;
      high_cnt <= win_end ? 16'h0000 : high_cnt + {15'h0000, pwm};
      if (win_end) begin
        duty <= high_cnt[15:8];
      end
    end
  end

  // ************************************************************
  // registers and mode decode
  // ************************************************************
  logic [7:0] brightness_field;
  logic [2:0] ctrl;
  logic backlight_on_status;
  logic [7:0] level;
  logic [18:0] on_cnt;
  wire duty_interpret_select = ctrl[`BSC_BIT_INTERP];
  wire source_pwm = ctrl[`BSC_BIT_SRC];
  wire backlight_on_control = ctrl[`BSC_BIT_ON];
  wire mode_pwm = source_pwm;
  wire mode_scaled = ~source_pwm & ~duty_interpret_select;

  function automatic logic [7:0] scale(input logic [7:0] a, input logic [7:0] b);
    logic [15:0] p;
    p = a * b + {8'h00, a};
    return p[15:8];
  endfunction

  // scaled value: register times duty fraction, full duty keeps value
  wire [7:0] scaled_level = scale(brightness_field, duty);
  wire [7:0] next_level = mode_pwm ? duty : (mode_scaled ? scaled_level : brightness_field);
  wire [7:0] read_bright = mode_pwm ? duty : brightness_field;
  wire [7:0] ctrl_read = {5'h00, ctrl};
  wire [7:0] status_read = {4'h0, backlight_on_status, 3'h0};

  // ************************************************************
  // smbus slave state machine
  // ************************************************************
  bsc_state_t state;
  bsc_state_t ack_ret;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] index;
  logic nak;
  logic is_read;
  logic got_cmd;
  logic sda_drive;
  logic wr_strobe;
  logic [7:0] wr_data;

  wire byte_done = scl_rise & (bit_cnt == 4'h7);
  wire [7:0] rx_byte = {shreg[6:0], sda};
  wire addr_hit = (rx_byte[7:1] == `BSC_SLAVE_ADDR);
  wire idx_ok = (rx_byte == `BSC_IDX_BRIGHT) | (rx_byte == `BSC_IDX_CTRL)
                | (rx_byte == `BSC_IDX_STATUS);
  wire [7:0] rd_val = (index == `BSC_IDX_BRIGHT) ? read_bright :
                      (index == `BSC_IDX_CTRL) ? ctrl_read : status_read;

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= BSC_IDLE;
      ack_ret <= BSC_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      index <= 8'h00;
      nak <= 1'b0;
      is_read <= 1'b0;
      got_cmd <= 1'b0;
      sda_drive <= 1'b0;
      wr_strobe <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_strobe <= 1'b0;
      if (start_cond) begin
        // repeated start only continues a read after a valid command
        state <= BSC_ADDR;
        bit_cnt <= 4'h0;
        sda_drive <= 1'b0;
      end else if (stop_cond) begin
        state <= BSC_IDLE;
        sda_drive <= 1'b0;
        got_cmd <= 1'b0;
      end else begin
        case (state)
          BSC_ADDR: begin
            if (scl_rise) begin
              shreg <= rx_byte;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done) begin
              is_read <= sda;
              // a read without a prior command is refused
              nak <= ~addr_hit | (sda & ~got_cmd);
              ack_ret <= ~addr_hit ? BSC_SKIP : (sda ? BSC_RDATA : BSC_CMD);
              state <= BSC_ACK;
            end
          end
          BSC_CMD: begin
            if (scl_rise) begin
              shreg <= rx_byte;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done) begin
              index <= rx_byte;
              got_cmd <= idx_ok;
              nak <= ~idx_ok;
              ack_ret <= idx_ok ? BSC_DATA : BSC_SKIP;
              state <= BSC_ACK;
            end
          end
          BSC_DATA: begin
            if (scl_rise) begin
              shreg <= rx_byte;
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (byte_done) begin
              // status is read only; extra bytes beyond one are refused
              nak <= (index == `BSC_IDX_STATUS);
              wr_strobe <= (index != `BSC_IDX_STATUS);
              wr_data <= rx_byte;
              got_cmd <= 1'b0;
              ack_ret <= BSC_SKIP;
              state <= BSC_ACK;
            end
          end
          BSC_ACK: begin
            // drive ack through the ninth clock; on its falling edge release it, or drive the first read bit
            if (scl_fall & ~sda_drive) begin
              sda_drive <= ~nak;
              bit_cnt <= 4'h0;
            end else if (scl_fall) begin
              sda_drive <= 1'b0;
              state <= ack_ret;
              if (ack_ret == BSC_RDATA) begin
                shreg <= rd_val;
                sda_drive <= ~rd_val[7];
              end
            end else if (scl_fall & nak) begin
              state <= BSC_SKIP;
            end
            if (nak & scl_rise) begin
              state <= BSC_SKIP;
            end
          end
          BSC_RDATA: begin
            // one data byte then wait for the host nak and stop
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 4'h1;
              shreg <= {shreg[6:0], 1'b0};
              sda_drive <= (bit_cnt < 4'h7) & ~shreg[6];
              if (bit_cnt == 4'h7) begin
                state <= BSC_SKIP;
              end
            end
          end
          BSC_SKIP: begin
            sda_drive <= 1'b0;
          end
          default: begin
            state <= BSC_IDLE;
          end
        endcase
      end
    end
  end

  // ************************************************************
  // register writes and backlight control
  // ************************************************************
  wire wr_bright = wr_strobe & (index == `BSC_IDX_BRIGHT) & ~mode_pwm;
  wire wr_ctrl = wr_strobe & (index == `BSC_IDX_CTRL);
  always_ff @(posedge clk) begin
    if (srst) begin
      brightness_field <= `BSC_BRIGHT_RST;
      ctrl <= `BSC_CTRL_RST;
    end else begin
      if (wr_bright) begin
        brightness_field <= wr_data;
      end
      if (wr_ctrl) begin
        ctrl <= wr_data[2:0];
      end
    end
  end

  // a 10 ms count fits 19 bits at 20 MHz; the on delay is kept short of it
  always_ff @(posedge clk) begin
    if (srst) begin
      backlight_on_status <= 1'b0;
      on_cnt <= 19'h00000;
      level <= `BSC_BRIGHT_RST;
    end else begin
      if (~backlight_on_control) begin
        backlight_on_status <= 1'b0;
        on_cnt <= 19'h00000;
      end else if (~backlight_on_status) begin
        on_cnt <= on_cnt + 19'h00001;
        backlight_on_status <= (on_cnt == `BSC_ON_CNT_LAST);
      end
      level <= next_level;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  // no stretching is ever done, so scl is never pulled low
  assign pins.scl_oe_n = 1'b1;
  assign pins.sda_oe_n = ~sda_drive;
  assign backlight.level = level;
  assign backlight.enable = backlight_on_status;
endmodule // bsc_regs
